// [design/pll_power_pkg.sv]
// constants, types and register map of the clock and power-mode controller
package pll_power_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam logic [10:0] PLL_MULT      = 11'd1275;

  // register byte addresses
  localparam logic [31:0] ADDR_POW_KEY1  = 32'hFFFF_0404;
  localparam logic [31:0] ADDR_POW_CFG   = 32'hFFFF_0408;
  localparam logic [31:0] ADDR_POW_KEY2  = 32'hFFFF_040C;
  localparam logic [31:0] ADDR_CLK_KEY1  = 32'hFFFF_0410;
  localparam logic [31:0] ADDR_CLK_CFG   = 32'hFFFF_0414;
  localparam logic [31:0] ADDR_CLK_KEY2  = 32'hFFFF_0418;
  localparam logic [31:0] ADDR_IRQ_STAT  = 32'hFFFF_0420;
  localparam logic [31:0] ADDR_IRQ_MASK  = 32'hFFFF_0424;
  localparam logic [31:0] ADDR_BLK_STATE = 32'hFFFF_0428;

  // key values
  localparam logic [15:0] CLK_KEY1_VAL = 16'h00AA;
  localparam logic [15:0] CLK_KEY2_VAL = 16'h0055;
  localparam logic [15:0] POW_KEY1_VAL = 16'h0001;
  localparam logic [15:0] POW_KEY2_VAL = 16'h00F4;

  // field positions and reset values
  localparam int unsigned SLOW_OSC_SELECT_BIT  = 5;
  localparam int unsigned CLOCK_SOURCE_MODE_LSB = 0;
  localparam int unsigned PC_LSB    = 4;
  localparam int unsigned CD_LSB    = 0;
  localparam logic [7:0]  CLK_CFG_RST = 8'h21;
  localparam logic [7:0]  POW_CFG_RST = 8'h03;

  // clock mode and pin function codes
  localparam logic [1:0] CLOCK_SOURCE_MODE_PLL      = 2'b01;
  localparam logic [1:0] CLOCK_SOURCE_MODE_EXT      = 2'b11;
  localparam logic [1:0] PIN_FUNC_EXTERNAL_CLOCK_INPUT  = 2'h2;
  localparam logic [1:0] PIN_FUNC_CORE_CLOCK_OUT_PIN  = 2'h3;

  // interrupt status bits
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_LOCK_BIT = 0;
  localparam int unsigned IRQ_WAKE_BIT = 1;
  localparam int unsigned IRQ_KEY_BIT  = 2;

  // wake latencies, as printed, and cycle counts
  localparam int unsigned WAKE_FAST_NS  = 24;
  localparam int unsigned WAKE_SLOW_NS  = 3060;
  localparam int unsigned WAKE_SLEEP_NS = 1580000;
  localparam int unsigned WAKE_STOP_NS  = 1700000;
  localparam int unsigned WAKE_SLOW_CYC  = (WAKE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_SLEEP_CYC = (WAKE_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_STOP_CYC  = (WAKE_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PM_ACTIVE = 3'b000,
    PM_PAUSE  = 3'b001,
    PM_NAP    = 3'b010,
    PM_SLEEP  = 3'b011,
    PM_STOP   = 3'b100
  } power_mode_t;

  typedef struct packed {
    logic       slow_osc_select;
    logic [1:0] clock_source_mode;
  } clk_cfg_t;

  typedef struct packed {
    power_mode_t power_mode_field;
    logic [2:0]  core_divider_select;
  } pow_cfg_t;

  typedef struct packed {
    logic core;
    logic periph;
    logic pll;
    logic xtal_timer;
    logic ext_irq;
  } domain_gate_t;

endpackage : pll_power_pkg

// [design/core_clock_divider.sv]
// binary core clock divider, tick and square output
`timescale 1ns/1ps
`default_nettype none
module core_clock_divider
  import pll_power_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] core_divider_select,
  // outputs
  output logic            tick,
  output logic            clk_out
);

  logic [6:0] count_r;
  logic       clk_out_r;
  logic [6:0] limit;

  // one tick every 2^cd cycles, each code halves the rate
  assign limit = 7'((8'h01 << core_divider_select) - 8'h01);
  assign tick  = run && (count_r >= limit);
  assign clk_out = clk_out_r;

  // counter stops while halted so the pin freezes too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r   <= 7'h00;
      clk_out_r <= 1'b0;
    end else if (tick) begin
      count_r   <= 7'h00;
      clk_out_r <= ~clk_out_r;
    end else if (run) begin
      count_r   <= count_r + 7'h01;
    end
  end

endmodule : core_clock_divider
`default_nettype wire

// [design/pll_clock_power_control.sv]
// clock source, power mode and key-protected register controller
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_power_control
  import pll_power_pkg::*;
#(
  parameter int unsigned SLEEP_WAKE_CYCLES = WAKE_SLEEP_CYC,
  parameter int unsigned STOP_WAKE_CYCLES  = WAKE_STOP_CYC,
  parameter int unsigned WAKE_CNT_W        = 16
) (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // asynchronous status and wake sources
  input  wire logic        pll_locked,
  input  wire logic [3:0]  ext_irq,
  input  wire logic        wakeup_timer_irq,
  // shared pin function from port logic
  input  wire logic [1:0]  pin_function,
  // shared clock pin
  input  wire logic        external_clock_input,
  output logic             core_clock_out_pin,
  output logic             core_clock_out_oe,
  // clock generation control
  output logic [10:0]      pll_multiplier,
  output logic             slow_osc_select,
  output logic [1:0]       clock_source_mode,
  output logic             ext_clock_in_use,
  output logic             core_clk_enable,
  output logic             core_tick,
  // domain gates
  output domain_gate_t     domain_gate,
  // interrupt
  output logic             irq
);

  if (SLEEP_WAKE_CYCLES < 1 || SLEEP_WAKE_CYCLES >= (1 << WAKE_CNT_W) ||
      STOP_WAKE_CYCLES < 1 || STOP_WAKE_CYCLES >= (1 << WAKE_CNT_W)) begin : g_bad_cfg
    $error("wake cycle counts must fit the wake counter and be nonzero");
  end

  typedef enum logic [2:0] {
    K_IDLE     = 3'b000,
    K_CLK_OPEN = 3'b001,
    K_CLK_HELD = 3'b010,
    K_POW_OPEN = 3'b011,
    K_POW_HELD = 3'b100
  } key_state_t;

  typedef enum logic [1:0] {
    PW_RUN  = 2'b00,
    PW_LOW  = 2'b01,
    PW_WAKE = 2'b10
  } pw_state_t;

  // wake latency for pause and nap grows with the divider
  function automatic logic [WAKE_CNT_W-1:0] nap_wake_cycles(input logic [2:0] cd);
    int unsigned ns;
    int unsigned cyc;
    ns  = WAKE_FAST_NS << cd;
    cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (cd == 3'h7) begin
      cyc = WAKE_SLOW_CYC;
    end
    if (cyc < 1) begin
      cyc = 1;
    end
    return WAKE_CNT_W'(cyc);
  endfunction : nap_wake_cycles

  // domains kept alive in each power mode
  function automatic domain_gate_t mode_gate(input power_mode_t pm);
    domain_gate_t g;
    g = '0;
    unique case (pm)
      PM_ACTIVE: g = '{core: 1'b1, periph: 1'b1, pll: 1'b1, xtal_timer: 1'b1, ext_irq: 1'b1};
      PM_PAUSE:  g = '{core: 1'b0, periph: 1'b1, pll: 1'b1, xtal_timer: 1'b1, ext_irq: 1'b1};
      PM_NAP:    g = '{core: 1'b0, periph: 1'b0, pll: 1'b1, xtal_timer: 1'b1, ext_irq: 1'b1};
      PM_SLEEP:  g = '{core: 1'b0, periph: 1'b0, pll: 1'b0, xtal_timer: 1'b1, ext_irq: 1'b1};
      PM_STOP:   g = '{core: 1'b0, periph: 1'b0, pll: 1'b0, xtal_timer: 1'b0, ext_irq: 1'b1};
      default:   g = '{core: 1'b1, periph: 1'b1, pll: 1'b1, xtal_timer: 1'b1, ext_irq: 1'b1};
    endcase
    return g;
  endfunction : mode_gate

  // state
  clk_cfg_t              clk_cfg_r;
  clk_cfg_t              clk_act_r;
  pow_cfg_t              pow_cfg_r;
  key_state_t            key_st_r;
  key_state_t            key_st_nxt;
  logic [7:0]            held_r;
  pw_state_t             pw_st_r;
  logic [WAKE_CNT_W-1:0] wake_cnt_r;
  logic [IRQ_W-1:0]      irq_stat_r;
  logic [IRQ_W-1:0]      irq_mask_r;
  logic [5:0]            sync1_r;
  logic [5:0]            sync2_r;
  logic [5:0]            sync3_r;
  logic [5:0]            filt_r;
  logic                  lock_prev_r;
  logic [31:0]           prdata_r;
  logic                  slverr_r;

  // apb decode
  logic        setup;
  logic        wr;
  logic [15:0] wkey;
  logic        hit_pk1;
  logic        hit_pcfg;
  logic        hit_pk2;
  logic        hit_ck1;
  logic        hit_ccfg;
  logic        hit_ck2;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_state;
  logic        mapped;

  assign setup     = psel && !penable;
  assign wr        = psel && penable && pwrite;
  assign wkey      = pwdata[15:0];
  assign hit_pk1   = (paddr == ADDR_POW_KEY1);
  assign hit_pcfg  = (paddr == ADDR_POW_CFG);
  assign hit_pk2   = (paddr == ADDR_POW_KEY2);
  assign hit_ck1   = (paddr == ADDR_CLK_KEY1);
  assign hit_ccfg  = (paddr == ADDR_CLK_CFG);
  assign hit_ck2   = (paddr == ADDR_CLK_KEY2);
  assign hit_stat  = (paddr == ADDR_IRQ_STAT);
  assign hit_mask  = (paddr == ADDR_IRQ_MASK);
  assign hit_state = (paddr == ADDR_BLK_STATE);
  assign mapped    = hit_pk1 | hit_pcfg | hit_pk2 | hit_ck1 | hit_ccfg | hit_ck2 |
                     hit_stat | hit_mask | hit_state;

  // key sequencing: key1, protected write, key2 with no other write between
  logic open_clk;
  logic open_pow;
  logic clk_commit;
  logic pow_commit;
  logic key_fault;

  assign open_clk = hit_ck1 && (wkey == CLK_KEY1_VAL);
  assign open_pow = hit_pk1 && (wkey == POW_KEY1_VAL);
  assign clk_commit = wr && (key_st_r == K_CLK_HELD) && hit_ck2 && (wkey == CLK_KEY2_VAL);
  assign pow_commit = wr && (key_st_r == K_POW_HELD) && hit_pk2 && (wkey == POW_KEY2_VAL);

  always_comb begin
    key_st_nxt = key_st_r;
    key_fault  = 1'b0;
    if (wr) begin
      key_st_nxt = open_clk ? K_CLK_OPEN : (open_pow ? K_POW_OPEN : K_IDLE);
      unique case (key_st_r)
        K_IDLE: begin
          key_fault = hit_ccfg | hit_pcfg;
        end
        K_CLK_OPEN: begin
          if (hit_ccfg) begin
            key_st_nxt = K_CLK_HELD;
          end else begin
            key_fault = 1'b1;
          end
        end
        K_POW_OPEN: begin
          if (hit_pcfg) begin
            key_st_nxt = K_POW_HELD;
          end else begin
            key_fault = 1'b1;
          end
        end
        K_CLK_HELD, K_POW_HELD: begin
          key_fault = !(clk_commit || pow_commit);
        end
        default: begin
          key_st_nxt = K_IDLE;
        end
      endcase
    end
  end

  // held value waits for the closing key before it lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_st_r <= K_IDLE;
      held_r   <= 8'h00;
    end else begin
      key_st_r <= key_st_nxt;
      if (wr && (hit_ccfg || hit_pcfg)) begin
        held_r <= pwdata[7:0];
      end
    end
  end

  // committed configuration; reserved power codes leave the mode alone
  logic        pc_legal;
  power_mode_t pc_held;

  assign pc_held  = power_mode_t'(held_r[PC_LSB +: 3]);
  assign pc_legal = (held_r[PC_LSB +: 3] <= PM_STOP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cfg_r <= clk_cfg_t'({CLK_CFG_RST[SLOW_OSC_SELECT_BIT], CLK_CFG_RST[CLOCK_SOURCE_MODE_LSB +: 2]});
      pow_cfg_r <= pow_cfg_t'({POW_CFG_RST[PC_LSB +: 3], POW_CFG_RST[CD_LSB +: 3]});
    end else begin
      if (clk_commit) begin
        clk_cfg_r.slow_osc_select   <= held_r[SLOW_OSC_SELECT_BIT];
        clk_cfg_r.clock_source_mode <= held_r[CLOCK_SOURCE_MODE_LSB +: 2];
      end
      if (pow_commit) begin
        pow_cfg_r.core_divider_select <= held_r[CD_LSB +: 3];
        if (pc_legal) begin
          pow_cfg_r.power_mode_field <= pc_held;
        end
      end else if (pw_st_r == PW_WAKE && wake_cnt_r == '0) begin
        pow_cfg_r.power_mode_field <= PM_ACTIVE;
      end
    end
  end

  // pin inputs: three flops, a rise counts once stages two and three agree, a fall as soon as they differ
  logic [5:0] pins;
  logic       lock_ok;
  logic [3:0] irq_pins;
  logic       timer_pin;

  assign pins      = {wakeup_timer_irq, ext_irq, pll_locked};
  assign lock_ok   = filt_r[0];
  assign irq_pins  = filt_r[4:1];
  assign timer_pin = filt_r[5];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      sync3_r <= 6'h00;
      filt_r  <= 6'h00;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= (sync2_r & sync3_r) | (filt_r & ~(sync2_r ^ sync3_r));
    end
  end

  // power sequencing: enter low power, wait for a wake source, count latency
  power_mode_t           pm;
  logic                  wake_src;
  logic [WAKE_CNT_W-1:0] wake_load;

  assign pm = pow_cfg_r.power_mode_field;
  assign wake_src = (pm == PM_STOP) ? (|irq_pins) : ((|irq_pins) | timer_pin);
  assign wake_load = (pm == PM_SLEEP) ? WAKE_CNT_W'(SLEEP_WAKE_CYCLES - 1) :
                     (pm == PM_STOP)  ? WAKE_CNT_W'(STOP_WAKE_CYCLES - 1) :
                     nap_wake_cycles(pow_cfg_r.core_divider_select) - 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_st_r    <= PW_RUN;
      wake_cnt_r <= '0;
      clk_act_r  <= clk_cfg_t'({CLK_CFG_RST[SLOW_OSC_SELECT_BIT], CLK_CFG_RST[CLOCK_SOURCE_MODE_LSB +: 2]});
    end else begin
      unique case (pw_st_r)
        PW_RUN: begin
          if (pm != PM_ACTIVE) begin
            pw_st_r   <= PW_LOW;
            clk_act_r <= clk_cfg_r;
          end
        end
        PW_LOW: begin
          if (wake_src) begin
            pw_st_r    <= PW_WAKE;
            wake_cnt_r <= wake_load;
          end
        end
        PW_WAKE: begin
          if (wake_cnt_r == '0) begin
            pw_st_r <= PW_RUN;
          end else begin
            wake_cnt_r <= wake_cnt_r - 1'b1;
          end
        end
        default: begin
          pw_st_r <= PW_RUN;
        end
      endcase
    end
  end

  // domain gating; during wake the clocks restart but the core stays held
  domain_gate_t wake_gate;

  assign wake_gate = '{core: 1'b0, periph: 1'b0, pll: 1'b1, xtal_timer: 1'b1, ext_irq: 1'b1};
  assign domain_gate = (pw_st_r == PW_WAKE) ? wake_gate :
                       (pw_st_r == PW_LOW)  ? mode_gate(pm) : mode_gate(PM_ACTIVE);

  // core clock: halted three cycles after the pll loses lock, while the filtered lock is low
  logic div_tick;
  logic div_clk;

  assign core_clk_enable = domain_gate.core && lock_ok;

  core_clock_divider u_div (
    .pclk                (pclk),
    .presetn             (presetn),
    .run                 (core_clk_enable),
    .core_divider_select (pow_cfg_r.core_divider_select),
    .tick                (div_tick),
    .clk_out             (div_clk)
  );

  assign core_tick = div_tick;

  // clock source; external clock only honoured with the pin in function two
  assign pll_multiplier    = PLL_MULT;
  assign slow_osc_select   = clk_act_r.slow_osc_select;
  assign clock_source_mode = clk_act_r.clock_source_mode;
  assign ext_clock_in_use  = (clk_act_r.clock_source_mode == CLOCK_SOURCE_MODE_EXT) &&
                             (pin_function == PIN_FUNC_EXTERNAL_CLOCK_INPUT);

  // shared pin drives the core clock only in its output function
  assign core_clock_out_pin = div_clk;
  assign core_clock_out_oe  = (pin_function == PIN_FUNC_CORE_CLOCK_OUT_PIN);

  // interrupt events; a set in the clear cycle wins
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_ready;
  logic             lock_fall;
  logic             wake_done;

  assign lock_fall = lock_prev_r && !lock_ok;
  assign wake_done = (pw_st_r == PW_WAKE) && (wake_cnt_r == '0);
  assign irq_set   = IRQ_W'({key_fault, wake_done, lock_fall});
  assign irq_clr   = (wr && hit_stat) ? pwdata[IRQ_W-1:0] : '0;
  // lock loss is only offered once lock is back
  assign irq_ready = {2'b11, lock_ok};
  assign irq       = |(irq_stat_r & irq_mask_r & irq_ready);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_prev_r <= 1'b0;
      irq_stat_r  <= '0;
      irq_mask_r  <= '0;
    end else begin
      lock_prev_r <= lock_ok;
      irq_stat_r  <= (irq_stat_r & ~irq_clr) | irq_set;
      if (wr && hit_mask) begin
        irq_mask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // read data formed in setup so the access phase answers at once
  logic [31:0] rd_mux;
  logic [31:0] state_word;

  assign state_word = {22'h000000, ext_clock_in_use, pw_st_r, pm,
                       clk_act_r.slow_osc_select, clk_act_r.clock_source_mode, lock_ok};
  assign rd_mux = hit_ccfg  ? {24'h000000, 2'b00, clk_cfg_r.slow_osc_select, 3'b000,
                               clk_cfg_r.clock_source_mode} :
                  hit_pcfg  ? {24'h000000, 1'b0, pm, 1'b0, pow_cfg_r.core_divider_select} :
                  hit_stat  ? {29'h00000000, irq_stat_r} :
                  hit_mask  ? {29'h00000000, irq_mask_r} :
                  hit_state ? state_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      slverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      slverr_r <= !mapped;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && slverr_r;

endmodule : pll_clock_power_control
`default_nettype wire

// [dv/pll_clock_power_control_checker.sv]
// port assertions for the clock and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module pll_clock_power_control_checker
  import pll_power_pkg::*;
(
  // clock, reset and bus
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic [31:0]  paddr,
  input wire logic         pready,
  input wire logic         pslverr,
  // pins and clock control
  input wire logic         pll_locked,
  input wire logic [1:0]   pin_function,
  input wire logic         core_clock_out_oe,
  input wire logic [10:0]  pll_multiplier,
  input wire logic [1:0]   clock_source_mode,
  input wire logic         ext_clock_in_use,
  input wire logic         core_clk_enable,
  input wire logic         core_tick,
  input wire domain_gate_t domain_gate,
  input wire logic         irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // access phase and address decode, full word compare
  wire acc    = psel && penable;
  wire mapped = paddr inside {ADDR_POW_KEY1, ADDR_POW_CFG, ADDR_POW_KEY2, ADDR_CLK_KEY1,
                              ADDR_CLK_CFG, ADDR_CLK_KEY2, ADDR_IRQ_STAT, ADDR_IRQ_MASK,
                              ADDR_BLK_STATE};

  AST_MULT: assert property (pll_multiplier == PLL_MULT)
    else $error("pll multiplier not constant");
  AST_TICK: assert property (core_tick |-> core_clk_enable && domain_gate.core)
    else $error("core tick while core halted");
  AST_OE: assert property (core_clock_out_oe == (pin_function == PIN_FUNC_CORE_CLOCK_OUT_PIN))
    else $error("core clock pin enable wrong");
  AST_SLVERR: assert property (acc && !mapped |-> pslverr && pready)
    else $error("unmapped access without error");
  // source may only switch while the core is stopped
  AST_SRC_HOLD: assert property (!$stable(clock_source_mode) |-> !domain_gate.core)
    else $error("clock source changed while core running");
  AST_LOCK_HALT: assert property (!pll_locked [*6] |-> !core_clk_enable)
    else $error("core clock runs without lock");
  AST_EXT_CLK: assert property (ext_clock_in_use ==
    (clock_source_mode == CLOCK_SOURCE_MODE_EXT && pin_function == PIN_FUNC_EXTERNAL_CLOCK_INPUT))
    else $error("external clock use flag wrong");
  AST_GATE_ORDER: assert property (!domain_gate.pll |-> !domain_gate.core && !domain_gate.periph)
    else $error("domains on with pll off");
  AST_EXT_ON: assert property (domain_gate.ext_irq)
    else $error("external interrupt domain gated");
  AST_CORE_EN: assert property (!domain_gate.core |-> !core_clk_enable && !core_tick)
    else $error("core enabled in low power");

  // main scenarios reached
  CV_NAP: cover property (domain_gate == 5'h07);
  CV_STOP: cover property (domain_gate == 5'h01);
  CV_LOCK: cover property ($fell(pll_locked));
  CV_IRQ: cover property (irq);
endmodule : pll_clock_power_control_checker

bind pll_clock_power_control pll_clock_power_control_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .pll_locked(pll_locked), .pin_function(pin_function),
  .core_clock_out_oe(core_clock_out_oe), .pll_multiplier(pll_multiplier),
  .clock_source_mode(clock_source_mode), .ext_clock_in_use(ext_clock_in_use),
  .core_clk_enable(core_clk_enable), .core_tick(core_tick), .domain_gate(domain_gate),
  .irq(irq));
`default_nettype wire

// [dv/pll_clock_power_control_tb_top.sv]
// self-checking bench for the clock and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module pll_clock_power_control_tb_top
  import pll_power_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pll_locked, wk, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [3:0] ext_irq;
  logic [1:0] pin_function, clock_source_mode;
  logic slow_osc_select, ext_clock_in_use, core_clk_enable, core_tick, pin_o, pin_oe;
  logic rerr;
  logic pin_prev;
  int   tg;
  domain_gate_t domain_gate;
  int err_count, check_count, k;

  pll_clock_power_control #(.SLEEP_WAKE_CYCLES(20), .STOP_WAKE_CYCLES(30)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_locked(pll_locked), .ext_irq(ext_irq), .wakeup_timer_irq(wk),
    .pin_function(pin_function), .external_clock_input(1'b0), .core_clock_out_pin(pin_o),
    .core_clock_out_oe(pin_oe), .pll_multiplier(), .slow_osc_select(slow_osc_select),
    .clock_source_mode(clock_source_mode), .ext_clock_in_use(ext_clock_in_use),
    .core_clk_enable(core_clk_enable), .core_tick(core_tick), .domain_gate(domain_gate),
    .irq(irq));

  // 100 ns clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, waits for pready, idle cycle after
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // bracketed write: power keys if pw, else clock keys
  task key_wr(input logic pw, input logic [31:0] cfg);
    apb(1'b1, pw ? ADDR_POW_KEY1 : ADDR_CLK_KEY1, {16'h0, pw ? POW_KEY1_VAL : CLK_KEY1_VAL});
    apb(1'b1, pw ? ADDR_POW_CFG : ADDR_CLK_CFG, cfg);
    apb(1'b1, pw ? ADDR_POW_KEY2 : ADDR_CLK_KEY2, {16'h0, pw ? POW_KEY2_VAL : CLK_KEY2_VAL});
  endtask : key_wr

  // counts wake cycles until all domains run; n of 0 skips the count
  task wake(input int n);
    k = 0;
    repeat (3000) if (domain_gate !== 5'h1F) begin
      @(posedge pclk);
      if (domain_gate === 5'h07) k++;
    end
    chk({27'h0, domain_gate}, 32'h1F);
    if (n > 0) chk(k, n);
  endtask : wake

  task summarize;
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    summarize();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    pll_locked = 1'b1; ext_irq = 4'h0; wk = 1'b0; pin_function = 2'h0;
    err_count = 0; check_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    // reset values and unmapped access
    rd(ADDR_CLK_CFG, 32'h21);
    rd(ADDR_POW_CFG, 32'h03);
    rd(ADDR_CLK_KEY1, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_BLK_STATE, 32'h0B);
    apb(1'b0, 32'hFFFF_0430, 32'h0);
    chk(rerr, 1'b1);
    // unbracketed, interrupted and wrong-key writes are dropped
    apb(1'b1, ADDR_POW_CFG, 32'h05);
    apb(1'b1, ADDR_POW_KEY1, 32'h01);
    apb(1'b1, 32'hFFFF_0430, 32'h0);
    apb(1'b1, ADDR_POW_CFG, 32'h05);
    apb(1'b1, ADDR_POW_KEY2, 32'hF4);
    apb(1'b1, ADDR_POW_KEY1, 32'h01);
    apb(1'b1, ADDR_POW_CFG, 32'h05);
    apb(1'b1, ADDR_POW_KEY2, 32'hF5);
    rd(ADDR_POW_CFG, 32'h03);
    rd(ADDR_IRQ_STAT, 32'h4);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h4);
    chk(irq, 1'b0);
    // every divider code: tick and pin toggle count over 256 cycles
    pin_function <= PIN_FUNC_CORE_CLOCK_OUT_PIN;
    for (int cd = 0; cd < 8; cd++) begin
      key_wr(1'b1, cd);
      rd(ADDR_POW_CFG, cd);
      repeat (8) @(posedge pclk);
      k = 0;
      tg = 0;
      pin_prev = pin_o;
      repeat (256) begin
        @(posedge pclk);
        if (core_tick === 1'b1) k++;
        if (pin_o !== pin_prev) tg++;
        pin_prev = pin_o;
      end
      chk(k, 256 >> cd);
      chk(tg, 256 >> cd);
    end
    chk(pin_oe, 1'b1);
    // crystal select, nap, timer wake
    key_wr(1'b0, 32'h01);
    rd(ADDR_CLK_CFG, 32'h01);
    chk(slow_osc_select, 1'b1);
    key_wr(1'b1, 32'h27);
    @(posedge pclk);
    chk({27'h0, domain_gate}, 32'h07);
    wk <= 1'b1;
    wake(0);
    wk <= 1'b0;
    chk({slow_osc_select, clock_source_mode}, 3'b001);
    rd(ADDR_POW_CFG, 32'h07);
    rd(ADDR_IRQ_STAT, 32'h2);
    apb(1'b1, ADDR_IRQ_STAT, 32'h2);
    // external clock through sleep, measured wake latency
    pin_function <= PIN_FUNC_EXTERNAL_CLOCK_INPUT;
    key_wr(1'b0, 32'h23);
    key_wr(1'b1, 32'h30);
    @(posedge pclk);
    chk({27'h0, domain_gate}, 32'h03);
    wk <= 1'b1;
    wake(20);
    wk <= 1'b0;
    chk(ext_clock_in_use, 1'b1);
    // stop ignores the timer, external interrupt wakes
    key_wr(1'b1, 32'h40);
    wk <= 1'b1;
    repeat (12) @(posedge pclk);
    chk({27'h0, domain_gate}, 32'h01);
    wk <= 1'b0;
    ext_irq <= 4'h4;
    wake(30);
    ext_irq <= 4'h0;
    // reserved mode code keeps mode, takes divider
    key_wr(1'b1, 32'h51);
    rd(ADDR_POW_CFG, 32'h01);
    // pause keeps peripherals, shortest wake latency
    key_wr(1'b1, 32'h10);
    @(posedge pclk);
    chk({27'h0, domain_gate}, 32'h0F);
    wk <= 1'b1;
    wake(1);
    wk <= 1'b0;
    // lock loss halts core, interrupt waits for relock
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    pll_locked <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({core_clk_enable, irq}, 2'b00);
    pll_locked <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({core_clk_enable, irq}, 2'b11);
    apb(1'b1, ADDR_IRQ_STAT, 32'h7);
    chk(irq, 1'b0);
    summarize();
  end
endmodule : pll_clock_power_control_tb_top
`default_nettype wire
